// *** hdl/upd_defs.vh ***
// upd_defs.vh: register offsets, fields, reset values and fixed usb figures
// assumes inclusion by bare name from the design files
`ifndef UPD_DEFS_VH
`define UPD_DEFS_VH

// register byte offsets on apb
`define UPD_OFS_CTRL       12'h000
`define UPD_OFS_STATUS     12'h004
`define UPD_OFS_ID         12'h008
`define UPD_OFS_FLOW       12'h00c
`define UPD_OFS_GPIO_MODE  12'h010
`define UPD_OFS_GPIO_DIR   12'h014
`define UPD_OFS_GPIO_MASK  12'h018
`define UPD_OFS_OTP_DEF    12'h01c
`define UPD_OFS_USB_FIX    12'h020

// control register fields
`define UPD_CTRL_CUSTOM    0
`define UPD_CTRL_OTP_VALID 1

// otp word fields
`define UPD_OTP_LP_POL     0
`define UPD_OTP_SENSE_EN   1

// class-driver defaults
`define UPD_DEF_FLOW       10'h001
`define UPD_DEF_GPIO_MODE  10'h001
`define UPD_DEF_GPIO_DIR   10'h008
`define UPD_DEF_GPIO_MASK  10'h030

// max power threshold: one unit load in 2 ma units
`define UPD_UNIT_LOAD      8'h32

// fixed usb topology figures
`define UPD_NUM_CTRL_EP    4'h1
`define UPD_CTRL_EP_NUM    4'h0
`define UPD_NUM_CONFIG     4'h1
`define UPD_NUM_IFACE      4'h2
`define UPD_NUM_INT_EP     4'h1
`define UPD_NUM_BULK_IN    4'h1
`define UPD_NUM_BULK_OUT   4'h1

// identity defaults, arbitrary neutral values
`define UPD_DEF_VID        16'h1234
`define UPD_DEF_PID        16'h5678

`endif

// *** hdl/upd_sync.v ***
// upd_sync.v: two flip-flop synchroniser for one asynchronous level
// assumes the input level is slow against pclk
`timescale 1ns/1ps
module upd_sync (
	input  wire pclk,      // clock
	input  wire presetn,   // async reset, low
	input  wire d,         // async level
	output wire q          // synchronised level
);
	reg s1_q;
	reg s2_q;

	// first stage feeds only the second
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
		end
	end
	assign q = s2_q;
endmodule

// *** hdl/upd_top.v ***
// upd_top.v: usb power indicator, pull-up gating, identity and class defaults
// assumes a usb core supplies suspend, configured, bus reset and max power
//
// Behaviour
// RULE_01: power-limit output asserted whenever full declared current is not allowed
// RULE_02: max power at most one unit load: assert only while suspended
// RULE_03: max power above one unit load: assert when suspended or unconfigured
// RULE_04: deassert when configured and not suspended
// RULE_05: otp bit chooses the indicator's active polarity
// RULE_06: with sensing on, drop data-line pull-up when bus supply absent
// RULE_07: otp bit enables sensing; otherwise pull-up not gated by sense
// RULE_08: exactly one control endpoint, number zero, default control pipe
// RULE_09: only one configuration reported and accepted
// RULE_10: two interfaces carrying one interrupt, one bulk-in, one bulk-out
// RULE_11: default vendor id reported, replaceable by otp programming
// RULE_12: default product id reported, replaceable by otp programming
// RULE_13: class defaults set flow control and gpio mode to one
// RULE_14: class defaults set gpio direction to eight
// RULE_15: class defaults set gpio interrupt mask to 0x030
// RULE_16: otp address/value entries replace built-in class defaults
// RULE_17: vendor driver sets custom-driver flag right after attach
// RULE_18: with custom flag set, class requests do not reapply defaults
// RULE_19: vendor driver programs its own pin and flow settings
// RULE_20: custom flag cleared on power-on reset and usb bus reset
//
// otp storage is modelled as apb-written shadow registers; the usb core
// levels share pclk and pass no synchroniser, only the sense pin does,
// so a change of bus supply reaches the pull-up three clocks later
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "upd_defs.vh"
module upd_top (
	input  wire        pclk,              // 40 mhz clock
	input  wire        presetn,           // async reset, low
	input  wire        psel,              // apb select
	input  wire        penable,           // apb enable
	input  wire        pwrite,            // apb direction
	input  wire [11:0] paddr,             // apb byte address
	input  wire [31:0] pwdata,            // apb write data
	output wire [31:0] prdata,            // apb read data
	output wire        pready,            // apb ready
	output wire        pslverr,           // apb error
	input  wire        usb_suspend,       // usb core suspended
	input  wire        usb_configured,    // host set configuration
	input  wire        usb_bus_reset,     // one-cycle usb bus reset
	input  wire        class_req,         // one-cycle class request seen
	input  wire [7:0]  max_power,         // declared max power, 2 ma units
	input  wire        bus_supply_sense,  // async bus supply pin
	input  wire        set_config_req,    // one-cycle set-config request
	input  wire [7:0]  set_config_val,    // requested configuration value
	output wire        config_accept,     // request accepted
	output wire        low_power,         // power-limit indicator
	output wire        positive_data_line_pu, // pull-up enable
	output wire [15:0] vendor_id,         // reported vendor id
	output wire [15:0] product_id,        // reported product id
	output wire [9:0]  flow_ctrl,         // flow control setting
	output wire [9:0]  gpio_mode,         // gpio mode setting
	output wire [9:0]  gpio_dir,          // gpio direction setting
	output wire [9:0]  gpio_mask          // gpio interrupt mask
);

////////////////////////////////////////////////////////////////////////////
	// apb decode helpers
	function hit;
		input [11:0] a;
		input [11:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	// access phase strobes; rd captures on the first access edge
	wire acc = psel & penable;
	wire rd  = acc & ~pwrite;

	// control flag and otp shadow bits
	reg        custom_q;
	reg        otp_valid_q;
	reg [1:0]  otp_q;

	// reported identity
	reg [15:0] vid_q;
	reg [15:0] pid_q;

	// live settings seen by the serial side
	reg [9:0]  flow_q;
	reg [9:0]  mode_q;
	reg [9:0]  dir_q;
	reg [9:0]  mask_q;

	// otp address/value entries for the class defaults
	reg [9:0]  otp_flow_q;
	reg [9:0]  otp_mode_q;
	reg [9:0]  otp_dir_q;
	reg [9:0]  otp_mask_q;

	// bus answer and pin drivers
	reg [31:0] rdata_q;
	reg        err_q;
	reg        lp_q;
	reg        pu_q;
	reg        acc_q;

	// writes land only at the edge where pready is seen high, so a
	// write is never applied twice across the wait state
	wire wr = acc & acc_q & pwrite;

	wire sense_s;

	// sense pin is asynchronous: two flops before any logic reads it
	upd_sync u_sense (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (bus_supply_sense),
		.q       (sense_s)
	);

	// mapped offsets; anything else answers with pslverr
	reg mapped;
	always @* begin
		if (hit(paddr, `UPD_OFS_CTRL))
			mapped = 1'b1;
		else if (hit(paddr, `UPD_OFS_STATUS))
			mapped = 1'b1;
		else if (hit(paddr, `UPD_OFS_ID))
			mapped = 1'b1;
		else if (hit(paddr, `UPD_OFS_FLOW))
			mapped = 1'b1;
		else if (hit(paddr, `UPD_OFS_GPIO_MODE))
			mapped = 1'b1;
		else if (hit(paddr, `UPD_OFS_GPIO_DIR))
			mapped = 1'b1;
		else if (hit(paddr, `UPD_OFS_GPIO_MASK))
			mapped = 1'b1;
		else if (hit(paddr, `UPD_OFS_OTP_DEF))
			mapped = 1'b1;
		else if (hit(paddr, `UPD_OFS_USB_FIX))
			mapped = 1'b1;
		else
			mapped = 1'b0;
	end

////////////////////////////////////////////////////////////////////////////
	// class defaults: built-in unless otp entries present
	wire [9:0] def_flow = otp_valid_q ? otp_flow_q : `UPD_DEF_FLOW; // RULE_16
	wire [9:0] def_mode = otp_valid_q ? otp_mode_q : `UPD_DEF_GPIO_MODE;
	wire [9:0] def_dir  = otp_valid_q ? otp_dir_q  : `UPD_DEF_GPIO_DIR;
	wire [9:0] def_mask = otp_valid_q ? otp_mask_q : `UPD_DEF_GPIO_MASK;

	// defaults reapplied on bus reset or class request without custom flag
	wire apply_def = usb_bus_reset | (class_req & ~custom_q); // RULE_18

	// control, otp shadow and identity registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			custom_q    <= 1'b0;             // RULE_20
			otp_valid_q <= 1'b0;
			otp_q       <= 2'h0;
			vid_q       <= `UPD_DEF_VID;     // RULE_11
			pid_q       <= `UPD_DEF_PID;     // RULE_12
			otp_flow_q  <= `UPD_DEF_FLOW;
			otp_mode_q  <= `UPD_DEF_GPIO_MODE;
			otp_dir_q   <= `UPD_DEF_GPIO_DIR;
			otp_mask_q  <= `UPD_DEF_GPIO_MASK;
		end else begin
			// bus reset clears the flag; a same-cycle write loses
			if (usb_bus_reset)
				custom_q <= 1'b0;            // RULE_20
			else if (wr && hit(paddr, `UPD_OFS_CTRL))
				custom_q <= pwdata[`UPD_CTRL_CUSTOM];
			// otp valid and the two otp bits follow the control word
			if (wr && hit(paddr, `UPD_OFS_CTRL)) begin
				otp_valid_q <= pwdata[`UPD_CTRL_OTP_VALID];
				otp_q       <= pwdata[3:2];
			end
			// identity replaced as one word, vendor in the low half
			if (wr && hit(paddr, `UPD_OFS_ID)) begin
				vid_q <= pwdata[15:0];       // RULE_11
				pid_q <= pwdata[31:16];      // RULE_12
			end
			// entries hold eight bits each; the top two bits stay zero
			if (wr && hit(paddr, `UPD_OFS_OTP_DEF)) begin
				otp_flow_q <= {2'h0, pwdata[7:0]};   // RULE_16
				otp_mode_q <= {2'h0, pwdata[15:8]};
				otp_dir_q  <= {2'h0, pwdata[23:16]};
				otp_mask_q <= {2'h0, pwdata[31:24]};
			end
		end
	end

	// live pin and flow settings
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flow_q <= `UPD_DEF_FLOW;          // RULE_13
			mode_q <= `UPD_DEF_GPIO_MODE;     // RULE_13
			dir_q  <= `UPD_DEF_GPIO_DIR;      // RULE_14
			mask_q <= `UPD_DEF_GPIO_MASK;     // RULE_15
		end else if (apply_def) begin
			// defaults win over a same-cycle settings write
			flow_q <= def_flow;               // RULE_13
			mode_q <= def_mode;               // RULE_13
			dir_q  <= def_dir;                // RULE_14
			mask_q <= def_mask;               // RULE_15
		end else if (wr) begin
			// custom driver writes its own settings
			if (hit(paddr, `UPD_OFS_FLOW))
				flow_q <= pwdata[9:0];
			else if (hit(paddr, `UPD_OFS_GPIO_MODE))
				mode_q <= pwdata[9:0];
			else if (hit(paddr, `UPD_OFS_GPIO_DIR))
				dir_q <= pwdata[9:0];
			else if (hit(paddr, `UPD_OFS_GPIO_MASK))
				mask_q <= pwdata[9:0];
		end
	end

////////////////////////////////////////////////////////////////////////////
	// power indicator and pull-up; registered so outputs are glitch free
	wire high_power = (max_power > `UPD_UNIT_LOAD);
	wire limit = usb_suspend |                      // RULE_02
	             (high_power & ~usb_configured);    // RULE_03
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lp_q <= 1'b0;
			pu_q <= 1'b0;
		end else begin
			// limit low when awake and either configured or at most one unit load
			lp_q <= limit ^ ~otp_q[`UPD_OTP_LP_POL]; // RULE_01 RULE_04 RULE_05
			pu_q <= ~otp_q[`UPD_OTP_SENSE_EN] | sense_s; // RULE_06 RULE_07
		end
	end

	// configuration: only value one (or zero to unconfigure) accepted
	assign config_accept = set_config_req &
	                       (set_config_val <= {4'h0, `UPD_NUM_CONFIG}); // RULE_09

////////////////////////////////////////////////////////////////////////////
	// read data and error registered in the access cycle's first edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= 32'h0000_0000;
			err_q   <= 1'b0;
			acc_q   <= 1'b0;
		end else begin
			// acc_q marks the second access cycle and drops after it
			acc_q <= acc & ~acc_q;
			err_q <= acc & ~acc_q & ~mapped;
			// capture once per transfer; prdata stands until next read
			if (rd && !acc_q) begin
				if (hit(paddr, `UPD_OFS_CTRL))
					rdata_q <= {28'h0, otp_q, otp_valid_q, custom_q};
				else if (hit(paddr, `UPD_OFS_STATUS))
					rdata_q <= {26'h0, sense_s, high_power, lp_q, pu_q,
					            usb_configured, usb_suspend};
				else if (hit(paddr, `UPD_OFS_ID))
					rdata_q <= {pid_q, vid_q};
				else if (hit(paddr, `UPD_OFS_FLOW))
					rdata_q <= {22'h0, flow_q};
				else if (hit(paddr, `UPD_OFS_GPIO_MODE))
					rdata_q <= {22'h0, mode_q};
				else if (hit(paddr, `UPD_OFS_GPIO_DIR))
					rdata_q <= {22'h0, dir_q};
				else if (hit(paddr, `UPD_OFS_GPIO_MASK))
					rdata_q <= {22'h0, mask_q};
				else if (hit(paddr, `UPD_OFS_OTP_DEF))
					rdata_q <= {otp_mask_q[7:0], otp_dir_q[7:0],
					            otp_mode_q[7:0], otp_flow_q[7:0]};
				else if (hit(paddr, `UPD_OFS_USB_FIX))
					rdata_q <= {4'h0, `UPD_NUM_BULK_OUT, `UPD_NUM_BULK_IN,
					            `UPD_NUM_INT_EP, `UPD_NUM_IFACE,  // RULE_10
					            `UPD_NUM_CONFIG,                  // RULE_09
					            `UPD_CTRL_EP_NUM, `UPD_NUM_CTRL_EP}; // RULE_08
				else
					rdata_q <= 32'h0000_0000;
			end
		end
	end

	// one wait state: ready on second access cycle
	assign pready  = acc_q;
	assign pslverr = err_q;
	assign prdata  = rdata_q;

	// pin and setting outputs straight from their flops
	assign low_power             = lp_q;
	assign positive_data_line_pu = pu_q;
	assign vendor_id             = vid_q;
	assign product_id            = pid_q;
	assign flow_ctrl             = flow_q;
	assign gpio_mode             = mode_q;
	assign gpio_dir              = dir_q;
	assign gpio_mask             = mask_q;
endmodule

// *** test/upd_top_props.sv ***
// upd_top_props.sv: port-level assertions for upd_top
// assumes binding into upd_top; ctrl and otp words shadowed from apb writes
`timescale 1ns/1ps
`include "upd_defs.vh"
module upd_props (
	input logic        pclk,                  // clock
	input logic        presetn,               // reset, low
	input logic        psel,                  // apb select
	input logic        penable,               // apb enable
	input logic        pwrite,                // apb direction
	input logic [11:0] paddr,                 // apb address
	input logic [31:0] pwdata,                // apb write data
	input logic        pready,                // apb ready
	input logic        usb_suspend,           // suspended
	input logic        usb_configured,        // configured
	input logic        usb_bus_reset,         // bus reset pulse
	input logic        class_req,             // class request pulse
	input logic [7:0]  max_power,             // declared power
	input logic        bus_supply_sense,      // supply pin
	input logic        set_config_req,        // set-config pulse
	input logic [7:0]  set_config_val,        // config value
	input logic        config_accept,         // accepted
	input logic        low_power,             // indicator
	input logic        positive_data_line_pu, // pull-up
	input logic [15:0] vendor_id,             // vendor id
	input logic [15:0] product_id,            // product id
	input logic [9:0]  flow_ctrl,             // flow setting
	input logic [9:0]  gpio_mode,             // mode setting
	input logic [9:0]  gpio_dir,              // direction setting
	input logic [9:0]  gpio_mask              // mask setting
);
	logic [31:0] ctl_q;
	logic [31:0] otp_q;
	logic        up_q;
	wire         wr = psel & penable & pready & pwrite;
	wire  [39:0] set_w = {gpio_mask, gpio_dir, gpio_mode, flow_ctrl};
	wire  [39:0] def_w = ctl_q[1] ? {2'b0, otp_q[31:24], 2'b0, otp_q[23:16],
		2'b0, otp_q[15:8], 2'b0, otp_q[7:0]} : {`UPD_DEF_GPIO_MASK,
		`UPD_DEF_GPIO_DIR, `UPD_DEF_GPIO_MODE, `UPD_DEF_FLOW};
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn || !up_q);
	////////////////////////////////////////////////////////////////////////
	// shadows; bus reset wins over a same-cycle custom write
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q <= 32'h0;
			otp_q <= 32'h0;
			up_q  <= 1'b0;
		end else begin
			// the release edge still sees reset in the flops
			up_q <= 1'b1;
			if (wr && paddr == `UPD_OFS_CTRL) ctl_q <= pwdata;
			if (wr && paddr == `UPD_OFS_OTP_DEF) otp_q <= pwdata;
			if (usb_bus_reset) ctl_q[0] <= 1'b0;
		end
	end
	chk_lp_low_load: assert property (max_power <= `UPD_UNIT_LOAD |=>
		low_power == ($past(usb_suspend) ~^ $past(ctl_q[2])))
		else $error("indicator wrong for low-power load");
	chk_lp_high_load: assert property (max_power > `UPD_UNIT_LOAD |=>
		low_power == (($past(usb_suspend) | !$past(usb_configured))
		~^ $past(ctl_q[2]))) else $error("indicator wrong for high load");
	chk_lp_safe: assert property (usb_configured && !usb_suspend |=>
		low_power == !$past(ctl_q[2])) else $error("indicator not idle");
	chk_pu_free: assert property (!ctl_q[3] |=> positive_data_line_pu)
		else $error("pull-up gated while sensing off");
	chk_pu_gated: assert property ((ctl_q[3] && !bus_supply_sense)[*4]
		|=> !positive_data_line_pu) else $error("pull-up kept without supply");
	chk_cfg_accept: assert property (config_accept ==
		(set_config_req && set_config_val <= 8'h01))
		else $error("configuration accept wrong");
	chk_id_reset: assert property ($rose(presetn) |->
		vendor_id == `UPD_DEF_VID && product_id == `UPD_DEF_PID)
		else $error("identity not at default");
	chk_defaults_apply: assert property (usb_bus_reset ||
		(class_req && !ctl_q[0]) |=> set_w == $past(def_w))
		else $error("class defaults not applied");
	chk_custom_keep: assert property (class_req && ctl_q[0] &&
		!usb_bus_reset |=> $stable(set_w)) else $error("defaults reapplied");
endmodule
bind upd_top upd_props chk_u (.*);

// *** test/upd_host_model.sv ***
// upd_host_model.sv: usb host stand-in driving the usb core status lines
// assumes the bench calls its tasks just after a rising edge
`timescale 1ns/1ps
module upd_host_model (
	input  logic       pclk,             // clock
	input  logic       config_accept,    // device answer
	output logic       usb_suspend,      // suspended
	output logic       usb_configured,   // configured
	output logic       usb_bus_reset,    // bus reset pulse
	output logic       class_req,        // class request pulse
	output logic       set_config_req,   // set-config pulse
	output logic [7:0] set_config_val,   // config value
	output logic [7:0] max_power,        // declared power
	output logic       bus_supply_sense  // supply present
);
	// attached and unconfigured at start
	initial begin
		{usb_suspend, usb_configured, usb_bus_reset, class_req} = 4'h0;
		{set_config_req, set_config_val, max_power} = 17'h0;
		bus_supply_sense = 1'b1;
	end
	task link(input logic s, input logic [7:0] mp);
		@(posedge pclk);
		usb_suspend <= s;
		max_power <= mp;
	endtask
	// configured only follows a request that the device accepted
	task cfg(input logic [7:0] v);
		@(posedge pclk);
		set_config_req <= 1'b1;
		set_config_val <= v;
		@(posedge pclk);
		if (config_accept) usb_configured <= (v != 8'h00);
		set_config_req <= 1'b0;
	endtask
	task pulse(input logic cls);
		@(posedge pclk);
		usb_bus_reset <= !cls;
		class_req <= cls;
		@(posedge pclk);
		usb_bus_reset <= 1'b0;
		class_req <= 1'b0;
	endtask
	task sense(input logic v);
		@(posedge pclk);
		bus_supply_sense <= v;
	endtask
endmodule

// *** test/tb_top.sv ***
// tb_top.sv: self-checking bench for upd_top over apb and usb status lines
// assumes upd_host_model drives the usb side and the checker is bound
`timescale 1ns/1ps
`include "upd_defs.vh"
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, se;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd;
	wire  [31:0] prdata;
	wire         pready, pslverr, config_accept, low_power;
	wire         positive_data_line_pu, usb_suspend, usb_configured;
	wire         usb_bus_reset, class_req, set_config_req, bus_supply_sense;
	wire  [7:0]  set_config_val, max_power;
	wire  [15:0] vendor_id, product_id;
	wire  [9:0]  flow_ctrl, gpio_mode, gpio_dir, gpio_mask;
	int          err_total = 0, checks_done = 0, cyc = 0;
	logic        lim;
	upd_top dut_u (
		.pclk                  (pclk),
		.presetn               (presetn),
		.psel                  (psel),
		.penable               (penable),
		.pwrite                (pwrite),
		.paddr                 (paddr),
		.pwdata                (pwdata),
		.prdata                (prdata),
		.pready                (pready),
		.pslverr               (pslverr),
		.usb_suspend           (usb_suspend),
		.usb_configured        (usb_configured),
		.usb_bus_reset         (usb_bus_reset),
		.class_req             (class_req),
		.max_power             (max_power),
		.bus_supply_sense      (bus_supply_sense),
		.set_config_req        (set_config_req),
		.set_config_val        (set_config_val),
		.config_accept         (config_accept),
		.low_power             (low_power),
		.positive_data_line_pu (positive_data_line_pu),
		.vendor_id             (vendor_id),
		.product_id            (product_id),
		.flow_ctrl             (flow_ctrl),
		.gpio_mode             (gpio_mode),
		.gpio_dir              (gpio_dir),
		.gpio_mask             (gpio_mask)
	);
	upd_host_model host_u (
		.pclk             (pclk),
		.config_accept    (config_accept),
		.usb_suspend      (usb_suspend),
		.usb_configured   (usb_configured),
		.usb_bus_reset    (usb_bus_reset),
		.class_req        (class_req),
		.set_config_req   (set_config_req),
		.set_config_val   (set_config_val),
		.max_power        (max_power),
		.bus_supply_sense (bus_supply_sense)
	);
	always #12.5 pclk = ~pclk;
	////////////////////////////////////////////////////////////////////////
	// a hang counts as a mismatch
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			wrap_up();
		end
	end
	task wrap_up;
		$display("errors %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task cmp_val(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task cmp_err(input logic g, input logic e);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t slverr %h exp %h", $time, g, e);
		end
	endtask
	// one transfer; waits on pready under a bound, data taken at that edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		se = pslverr;
		{psel, penable} <= 2'b00;
		if (n >= 20) err_total++;
	endtask
	task tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task chk_set(input logic [39:0] e);
		cmp_val({12'h0, gpio_mode, flow_ctrl}, {12'h0, e[19:0]});
		cmp_val({12'h0, gpio_mask, gpio_dir}, {12'h0, e[39:20]});
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{pclk, presetn, psel, penable, pwrite} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		tick(16);
		presetn <= 1'b1;
		tick(2);
		cmp_val({vendor_id, product_id}, {`UPD_DEF_VID, `UPD_DEF_PID});
		chk_set({10'h030, 10'h008, 10'h001, 10'h001});
		apb(1'b0, `UPD_OFS_USB_FIX, 32'h0);
		cmp_val(rd, 32'h0111_2101);
		// supply present, low load, awake, unconfigured, active low
		apb(1'b0, `UPD_OFS_STATUS, 32'h0);
		cmp_val(rd, 32'h0000_002c);
		apb(1'b0, 12'h0f0, 32'h0);
		cmp_err(se, 1'b1);
		// indicator over both polarities, both loads at the 0x32 boundary
		for (int i = 0; i < 16; i++) begin
			if (i % 8 == 0) apb(1'b1, `UPD_OFS_CTRL, 32'(i[3]) << 2);
			host_u.link(i[0], i[2] ? 8'h33 : 8'h32);
			host_u.cfg({7'h0, i[1]});
			host_u.cfg(8'h02);
			tick(3);
			lim = i[0] | (i[2] & !i[1]);
			cmp_val({31'h0, low_power}, {31'h0, lim ~^ i[3]});
		end
		// pull-up gating by supply sense
		apb(1'b1, `UPD_OFS_CTRL, 32'h8);
		host_u.sense(1'b0);
		tick(6);
		cmp_val({31'h0, positive_data_line_pu}, 32'h0);
		host_u.sense(1'b1);
		tick(6);
		cmp_val({31'h0, positive_data_line_pu}, 32'h1);
		apb(1'b1, `UPD_OFS_CTRL, 32'h0);
		host_u.sense(1'b0);
		tick(6);
		cmp_val({31'h0, positive_data_line_pu}, 32'h1);
		apb(1'b1, `UPD_OFS_ID, 32'hbeef_cafe);
		tick(2);
		cmp_val({product_id, vendor_id}, 32'hbeef_cafe);
		// class requests reapply defaults until the custom flag is set
		apb(1'b1, `UPD_OFS_FLOW, 32'h5);
		host_u.pulse(1'b1);
		tick(1);
		cmp_val({22'h0, flow_ctrl}, 32'h1);
		apb(1'b1, `UPD_OFS_CTRL, 32'h1);
		apb(1'b1, `UPD_OFS_FLOW, 32'h5);
		host_u.pulse(1'b1);
		tick(1);
		cmp_val({22'h0, flow_ctrl}, 32'h5);
		host_u.pulse(1'b0);
		apb(1'b1, `UPD_OFS_FLOW, 32'h5);
		host_u.pulse(1'b1);
		tick(1);
		cmp_val({22'h0, flow_ctrl}, 32'h1);
		// otp entries replace the built-in defaults
		apb(1'b1, `UPD_OFS_OTP_DEF, 32'h0504_0302);
		apb(1'b1, `UPD_OFS_CTRL, 32'h2);
		host_u.pulse(1'b0);
		tick(1);
		chk_set({10'h005, 10'h004, 10'h003, 10'h002});
		// a power-on reset in mid-run clears the custom flag as well
		apb(1'b1, `UPD_OFS_CTRL, 32'h1);
		presetn <= 1'b0;
		tick(4);
		presetn <= 1'b1;
		tick(2);
		cmp_val({16'h0, vendor_id}, {16'h0, `UPD_DEF_VID});
		apb(1'b0, `UPD_OFS_CTRL, 32'h0);
		cmp_val(rd, 32'h0000_0000);
		apb(1'b1, `UPD_OFS_FLOW, 32'h5);
		host_u.pulse(1'b1);
		tick(1);
		cmp_val({22'h0, flow_ctrl}, 32'h1);
		wrap_up();
	end
endmodule
